/* hw/cmix_qmc_pkg.sv */
package cmix_qmc_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int SAMPLE_W   = 16;
    localparam int GAIN_W     = 11;
    localparam int PHASE_W    = 12;
    localparam int OFFSET_W   = 13;
    localparam int FIFO_DEPTH = 32;

    // ****************************************************************
    // register map (plain port, word addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_MIX_CTRL = 4'h0;
    localparam logic [3:0] ADDR_GAIN     = 4'h1;
    localparam logic [3:0] ADDR_PHASE    = 4'h2;
    localparam logic [3:0] ADDR_OFFS_I   = 4'h3;
    localparam logic [3:0] ADDR_OFFS_Q   = 4'h4;
    localparam logic [3:0] ADDR_STATUS   = 4'h5;

    // mix control field positions
    localparam int MIX_SEL_LSB   = 0;
    localparam int MIX_GAIN_BIT  = 4;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [3:0]          RST_MIX_SEL  = 4'h0;
    localparam logic                RST_MIX_GAIN = 1'b0;
    localparam logic [GAIN_W-1:0]   RST_GAIN     = 11'h400;
    localparam logic [PHASE_W-1:0]  RST_PHASE    = 12'h000;
    localparam logic [OFFSET_W-1:0] RST_OFFSET   = 13'h0000;

    // coarse mixer selector bits
    localparam int SEL_EIGHTH  = 3;
    localparam int SEL_POS_QTR = 2;
    localparam int SEL_HALF    = 1;
    localparam int SEL_NEG_QTR = 0;

    // fixed eighth-rate coefficient, cos(pi/4) in Q1.14
    localparam logic signed [15:0] COS_EIGHTH = 16'sh2D41;
    localparam int COEF_FRAC  = 14;
    localparam int GAIN_FRAC  = 10;
    localparam int PHASE_FRAC = 12;

    localparam logic signed [SAMPLE_W-1:0] SAT_MAX = 16'sh7FFF;
    localparam logic signed [SAMPLE_W-1:0] SAT_MIN = -16'sh8000;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] i;
        logic signed [SAMPLE_W-1:0] q;
    } iq_t;

    typedef enum logic [1:0] {
        PH_0 = 2'b00,
        PH_1 = 2'b01,
        PH_2 = 2'b11,
        PH_3 = 2'b10
    } phase_t;

endpackage : cmix_qmc_pkg

/* hw/iq_fifo.sv */
`timescale 1ns/1ns
module iq_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;

    assign o_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign o_valid = wr_q != rd_q;
    assign o_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : iq_fifo

/* hw/coarse_mixer_iq_correction.sv */
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module coarse_mixer_iq_correction (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic [31:0] i_iq,
    input  wire logic        i_iq_valid,
    output logic             o_iq_ready,
    output logic      [15:0] o_dac_i,
    output logic      [15:0] o_dac_q,
    output logic             o_dac_valid
);
    // ****************************************************************
    // saturation helper
    // ****************************************************************
    function automatic logic signed [15:0] sat16(
        input logic signed [47:0] v);
        if (v > 48'(cmix_qmc_pkg::SAT_MAX)) begin
            sat16 = cmix_qmc_pkg::SAT_MAX;
        end else if (v < 48'(cmix_qmc_pkg::SAT_MIN)) begin
            sat16 = cmix_qmc_pkg::SAT_MIN;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [3:0]  mix_sel_q;
    logic        mix_gain_q;
    logic [10:0] gain_q;
    logic [11:0] phase_q;
    logic [12:0] offs_i_q;
    logic [12:0] offs_q_q;
    logic [31:0] rdata_q;
    logic [31:0] sat_cnt_q;

    wire wr_ctrl = i_wr && i_addr == cmix_qmc_pkg::ADDR_MIX_CTRL;
    wire [3:0] sel_wr = i_wdata[cmix_qmc_pkg::MIX_SEL_LSB +: 4];
    wire sel_change = wr_ctrl && sel_wr != mix_sel_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mix_sel_q  <= cmix_qmc_pkg::RST_MIX_SEL;
            mix_gain_q <= cmix_qmc_pkg::RST_MIX_GAIN;
            gain_q     <= cmix_qmc_pkg::RST_GAIN;
            phase_q    <= cmix_qmc_pkg::RST_PHASE;
            offs_i_q   <= cmix_qmc_pkg::RST_OFFSET;
            offs_q_q   <= cmix_qmc_pkg::RST_OFFSET;
        end else if (i_wr) begin
            case (i_addr)
                cmix_qmc_pkg::ADDR_MIX_CTRL: begin
                    mix_sel_q  <= sel_wr;
                    mix_gain_q <= i_wdata[cmix_qmc_pkg::MIX_GAIN_BIT];
                end
                cmix_qmc_pkg::ADDR_GAIN:   gain_q   <= i_wdata[10:0];
                cmix_qmc_pkg::ADDR_PHASE:  phase_q  <= i_wdata[11:0];
                cmix_qmc_pkg::ADDR_OFFS_I: offs_i_q <= i_wdata[12:0];
                cmix_qmc_pkg::ADDR_OFFS_Q: offs_q_q <= i_wdata[12:0];
                default: ;
            endcase
        end
    end

    wire [31:0] rd_mux =
        (i_addr == cmix_qmc_pkg::ADDR_MIX_CTRL) ?
            {27'h0, mix_gain_q, mix_sel_q} :
        (i_addr == cmix_qmc_pkg::ADDR_GAIN)   ? {21'h0, gain_q} :
        (i_addr == cmix_qmc_pkg::ADDR_PHASE)  ? {20'h0, phase_q} :
        (i_addr == cmix_qmc_pkg::ADDR_OFFS_I) ? {19'h0, offs_i_q} :
        (i_addr == cmix_qmc_pkg::ADDR_OFFS_Q) ? {19'h0, offs_q_q} :
        (i_addr == cmix_qmc_pkg::ADDR_STATUS) ? sat_cnt_q : 32'h0;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= i_rd ? rd_mux : 32'h0;
        end
    end
    assign o_rdata = rdata_q;

    // ****************************************************************
    // input buffer
    // ****************************************************************
    logic [31:0] f_data;
    logic        f_valid;
    logic        f_ready;
    logic        fifo_in_ready;

    // output register never stalls, so the drain side is always ready
    assign f_ready = 1'b1;

    iq_fifo #(
        .WIDTH (32),
        .DEPTH (cmix_qmc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_data    (i_iq),
        .i_valid   (i_iq_valid),
        .o_ready   (fifo_in_ready),
        .o_data    (f_data),
        .o_valid   (f_valid),
        .i_ready   (f_ready)
    );

    logic ready_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= fifo_in_ready;
        end
    end
    // registered ready lags by a cycle; producer must tolerate one extra
    assign o_iq_ready = ready_q;

    // ****************************************************************
    // sample position
    // ****************************************************************
    cmix_qmc_pkg::phase_t pos_q;
    cmix_qmc_pkg::phase_t pos_d;
    always_comb begin
        case (pos_q)
            cmix_qmc_pkg::PH_0: pos_d = cmix_qmc_pkg::PH_1;
            cmix_qmc_pkg::PH_1: pos_d = cmix_qmc_pkg::PH_2;
            cmix_qmc_pkg::PH_2: pos_d = cmix_qmc_pkg::PH_3;
            default:            pos_d = cmix_qmc_pkg::PH_0;
        endcase
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || sel_change) begin
            pos_q <= cmix_qmc_pkg::PH_0;
        end else if (f_valid) begin
            pos_q <= pos_d;
        end
    end

    // ****************************************************************
    // swap and negate mixers
    // ****************************************************************
    cmix_qmc_pkg::iq_t s0;
    assign s0 = f_data;
    wire signed [16:0] in_i = 17'(s0.i);
    wire signed [16:0] in_q = 17'(s0.q);

    logic signed [16:0] m_i;
    logic signed [16:0] m_q;
    // 17 bits keep negation of the most negative sample exact
    always_comb begin
        m_i = in_i;
        m_q = in_q;
        if (mix_sel_q[cmix_qmc_pkg::SEL_POS_QTR]) begin
            case (pos_q)
                cmix_qmc_pkg::PH_1: begin m_i = -in_q; m_q =  in_i; end
                cmix_qmc_pkg::PH_2: begin m_i = -in_i; m_q = -in_q; end
                cmix_qmc_pkg::PH_3: begin m_i =  in_q; m_q = -in_i; end
                default: ;
            endcase
        end else if (mix_sel_q[cmix_qmc_pkg::SEL_NEG_QTR]) begin
            case (pos_q)
                cmix_qmc_pkg::PH_1: begin m_i =  in_q; m_q = -in_i; end
                cmix_qmc_pkg::PH_2: begin m_i = -in_i; m_q = -in_q; end
                cmix_qmc_pkg::PH_3: begin m_i = -in_q; m_q =  in_i; end
                default: ;
            endcase
        end
        // odd positions negate when half-rate is set, cascading too
        if (mix_sel_q[cmix_qmc_pkg::SEL_HALF] && pos_q[0] ^ pos_q[1])
        begin
            m_i = -m_i;
            m_q = -m_q;
        end
    end

    // ****************************************************************
    // eighth-rate complex multiplier
    // ****************************************************************
    logic [2:0] oct_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || sel_change) begin
            oct_q <= 3'h0;
        end else if (f_valid) begin
            oct_q <= oct_q + 3'h1;
        end
    end

    // cos and sin of oct*pi/4 as -1,0,+1 times COS_EIGHTH or full
    wire signed [16:0] k = 17'(cmix_qmc_pkg::COS_EIGHTH);
    wire signed [16:0] one = 17'sh04000;
    logic signed [16:0] c_k;
    logic signed [16:0] s_k;
    always_comb begin
        case (oct_q)
            3'h0: begin c_k =  one; s_k = 17'sh0; end
            3'h1: begin c_k =  k;   s_k =  k;    end
            3'h2: begin c_k = 17'sh0; s_k = one; end
            3'h3: begin c_k = -k;   s_k =  k;    end
            3'h4: begin c_k = -one; s_k = 17'sh0; end
            3'h5: begin c_k = -k;   s_k = -k;    end
            3'h6: begin c_k = 17'sh0; s_k = -one; end
            default: begin c_k = k; s_k = -k; end
        endcase
    end

    wire signed [47:0] p_i = 48'(m_i * c_k) - 48'(m_q * s_k);
    wire signed [47:0] p_q = 48'(m_i * s_k) + 48'(m_q * c_k);
    // gain bit 0 drops one more bit of scale
    wire [4:0] shft = mix_gain_q ? 5'(cmix_qmc_pkg::COEF_FRAC)
                                 : 5'(cmix_qmc_pkg::COEF_FRAC + 1);
    wire signed [47:0] e_i = p_i >>> shft;
    wire signed [47:0] e_q = p_q >>> shft;

    wire use_mult = mix_sel_q[cmix_qmc_pkg::SEL_EIGHTH];
    wire signed [15:0] x_i = use_mult ? sat16(e_i)
                                      : sat16(48'(m_i));
    wire signed [15:0] x_q = use_mult ? sat16(e_q) : sat16(48'(m_q));

    // ****************************************************************
    // gain, phase, offset
    // ****************************************************************
    wire signed [11:0] gain_s = signed'({1'b0, gain_q});
    wire signed [47:0] g_i = 48'(x_i * gain_s) >>>
                             cmix_qmc_pkg::GAIN_FRAC;
    wire signed [47:0] g_q = 48'(x_q * gain_s) >>> cmix_qmc_pkg::GAIN_FRAC;
    wire signed [11:0] ph_s = signed'(phase_q);
    // full 12-bit fraction keeps the constant inside -0.5 .. +0.49975
    wire signed [47:0] ph_term = 48'(x_q * ph_s) >>>
                                 cmix_qmc_pkg::PHASE_FRAC;
    wire signed [47:0] c_i = g_i + ph_term;
    wire signed [47:0] o_i = 48'(sat16(c_i)) +
                             48'(signed'(offs_i_q));
    wire signed [47:0] o_q = 48'(sat16(g_q)) + 48'(signed'(offs_q_q));
    wire signed [15:0] fin_i = sat16(o_i);
    wire signed [15:0] fin_q = sat16(o_q);
    wire clip = f_valid && (fin_i != o_i[15:0] || fin_q != o_q[15:0] ||
                sat16(c_i) != c_i[15:0]);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_dac_i     <= 16'h0000;
            o_dac_q     <= 16'h0000;
            o_dac_valid <= 1'b0;
            sat_cnt_q   <= 32'h0;
        end else begin
            o_dac_valid <= f_valid;
            if (f_valid) begin
                o_dac_i <= fin_i;
                o_dac_q <= fin_q;
            end
            if (clip && sat_cnt_q != 32'hFFFFFFFF) begin
                sat_cnt_q <= sat_cnt_q + 32'h1;
            end
        end
    end
endmodule : coarse_mixer_iq_correction

/* testbench/cmix_checker.sv */
`timescale 1ns/1ns
module cmix_checker (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [31:0] o_rdata,
    input  wire logic        i_iq_valid,
    input  wire logic        o_iq_ready,
    input  wire logic [15:0] o_dac_i,
    input  wire logic [15:0] o_dac_q,
    input  wire logic        o_dac_valid
);
    // ****************************************************************
    // port relations
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire take = i_iq_valid && o_iq_ready;
    sequence wr_gain;
        i_wr && i_addr == 4'h1;
    endsequence
    sequence rd_gain;
        i_rd && i_addr == 4'h1;
    endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_unmapped_read: assert property (i_rd && i_addr > 4'h5 |=> !o_rdata)
        else $error("unmapped read not zero");
    a_gain_readback: assert property (wr_gain ##1 rd_gain |=>
        o_rdata == ($past(i_wdata, 2) & 32'h7FF))
        else $error("gain readback wrong");
    a_take_to_out: assert property (take |-> ##2 o_dac_valid)
        else $error("sample not delivered in two cycles");
    a_out_cause: assert property (o_dac_valid |-> $past(take, 2))
        else $error("output without a taken sample");
    a_dac_hold: assert property (!o_dac_valid |->
        $stable(o_dac_i) && $stable(o_dac_q))
        else $error("outputs moved without valid");
    a_ready_rise: assert property ($fell(i_rst) |-> ##[1:2] o_iq_ready)
        else $error("ready late after reset");
    a_reset_quiet: assert property ($fell(i_rst) |->
        !o_dac_valid && !o_iq_ready && o_rdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule : cmix_checker

bind coarse_mixer_iq_correction cmix_checker u_chk (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .i_iq_valid (i_iq_valid),
    .o_iq_ready (o_iq_ready),
    .o_dac_i    (o_dac_i),
    .o_dac_q    (o_dac_q),
    .o_dac_valid(o_dac_valid)
);

/* testbench/iq_source.sv */
`timescale 1ns/1ns
module iq_source (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ready,
    output logic      [31:0] o_iq,
    output logic             o_valid
);
    logic [31:0] q[$];
    int          stall = 0;
    int          gap   = 0;
    initial begin
        o_iq    = 32'h0;
        o_valid = 1'b0;
    end
    // ****************************************************************
    // hold each sample until taken; idle data toggles, never stale
    // ****************************************************************
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
        end else if (!o_valid || i_ready) begin
            if (gap > 0 || q.size() == 0) begin
                gap = (gap > 0) ? gap - 1 : 0;
                o_valid <= 1'b0;
                o_iq    <= ~o_iq;
            end else begin
                o_valid <= 1'b1;
                o_iq    <= q.pop_front();
                gap = stall;
            end
        end
    end
endmodule : iq_source

/* testbench/test_coarse_mixer_iq_correction.sv */
`timescale 1ns/1ns
module test_coarse_mixer_iq_correction;
    typedef struct {
        logic        care;
        logic [15:0] i;
        logic [15:0] q;
    } exp_t;
    logic        sys_clk, rst, wr, rd, iq_valid, iq_ready, dac_valid;
    logic [3:0]  addr, sel;
    logic [31:0] wdata, rdata, iq, r;
    logic [15:0] dac_i, dac_q;
    logic        gbit;
    int          gain, phase, offi, offq, pos, failures, n_checks, cyc;
    exp_t        exp_q[$];
    exp_t        m_e;
    logic [4:0]  md[10] = '{5'h00, 5'h02, 5'h04, 5'h01, 5'h08,
                            5'h18, 5'h0A, 5'h0C, 5'h0E, 5'h02};
    int          tv[6][6] = '{'{512, 0, 0, 0, 1000, -2000},
                              '{2047, 0, 0, 0, 20000, -20000},
                              '{1024, 2048, 0, 0, 100, 4096},
                              '{1024, 2047, 0, 0, 0, 4096},
                              '{1024, 0, 4096, 4095, 0, 0},
                              '{1024, 0, 4096, 4095, -30000, 30000}};
    coarse_mixer_iq_correction DUT (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_iq(iq), .i_iq_valid(iq_valid), .o_iq_ready(iq_ready),
        .o_dac_i(dac_i), .o_dac_q(dac_q), .o_dac_valid(dac_valid));
    iq_source src (.i_sys_clk(sys_clk), .i_rst(rst), .i_ready(iq_ready),
        .o_iq(iq), .o_valid(iq_valid));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    function automatic logic [15:0] sat(input longint v);
        return v > 32767 ? 16'h7FFF : (v < -32768 ? 16'h8000 : v[15:0]);
    endfunction : sat
    // arithmetic right shift rounds toward minus infinity, so floor here
    function automatic longint fdiv(input longint a, input longint b);
        return (a < 0 && a % b != 0) ? a / b - 1 : a / b;
    endfunction : fdiv
    task automatic acc(input logic w, input logic rr, input logic [3:0] a,
                       input logic [31:0] d);
        wr    <= w;
        rd    <= rr;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
    endtask : acc
    task automatic rreg(input logic [3:0] a, input logic [31:0] want);
        acc(1'b0, 1'b1, a, 32'h0);
        #1;
        chk(rdata, want);
    endtask : rreg
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        acc(1'b1, 1'b0, a, d);
        if (a == 4'h0 && d[3:0] != sel) pos = 0;
        if (a == 4'h0) {gbit, sel} = d[4:0];
        if (a == 4'h1) gain = d[10:0];
        if (a == 4'h2) phase = int'($signed(d[11:0]));
        if (a == 4'h3) offi = int'($signed(d[12:0]));
        if (a == 4'h4) offq = int'($signed(d[12:0]));
    endtask : wreg
    task automatic push(input int i, input int q);
        exp_t e;
        int   k, t, mi, mq;
        k  = (sel[3] ? pos / 2 : 0) + (sel[2] ? pos : 0)
           + (sel[1] ? 2 * pos : 0) + (sel[0] ? 3 * pos : 0);
        mi = i;
        mq = q;
        repeat (k % 4) begin
            t  = mi;
            mi = -mq;
            mq = t;
        end
        if (sel[3] && !gbit) begin
            mi = mi / 2;
            mq = mq / 2;
        end
        e.care = !(sel[3] && pos % 2 == 1);
        e.i = sat(fdiv(longint'(mi) * gain, 1024)
                + fdiv(longint'(mq) * phase, 4096) + offi);
        e.q = sat(fdiv(longint'(mq) * gain, 1024) + offq);
        src.q.push_back({i[15:0], q[15:0]});
        exp_q.push_back(e);
        pos++;
    endtask : push
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (3) @(posedge sys_clk);
    endtask : drain
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // ****************************************************************
    // result watcher and hang guard
    // ****************************************************************
    always @(negedge sys_clk) begin
        if (dac_valid === 1'b1 && exp_q.size() == 0) begin
            failures++;
            $display("MISMATCH %0t unexpected sample", $time);
        end else if (dac_valid === 1'b1) begin
            m_e = exp_q.pop_front();
            if (m_e.care) chk(dac_i, m_e.i);
            if (m_e.care) chk(dac_q, m_e.q);
        end
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        {rst, wr, rd, addr, wdata} = {1'b1, 38'h0};
        {gbit, sel, gain, phase, offi, offq, pos} = {5'h0, 32'd1024, 128'h0};
        {failures, n_checks, cyc} = 96'h0;
        void'($urandom(32'h64B2));
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rreg(4'h0, 32'h0);
        rreg(4'h1, 32'h400);
        rreg(4'h2, 32'h0);
        rreg(4'h3, 32'h0);
        rreg(4'h4, 32'h0);
        rreg(4'h5, 32'h0);
        acc(1'b1, 1'b0, 4'hF, 32'hFFFF);
        rreg(4'hF, 32'h0);
        wreg(4'h1, 32'hFFFFFFFF);
        rreg(4'h1, 32'h7FF);
        wreg(4'h1, 32'h400);
        acc(1'b0, 1'b0, 4'h0, 32'h0);
        $display("test registers done");
        foreach (md[m]) begin
            wreg(4'h0, {27'h0, md[m]});
            acc(1'b0, 1'b0, 4'h0, 32'h0);
            src.stall = m % 3;
            repeat (5) begin
                r = $urandom;
                push(int'($signed(r[30:16])) & -2, int'($signed(r[14:0])) & -2);
            end
            drain();
            $display("test mix %h done", md[m]);
        end
        wreg(4'h0, 32'h0);
        foreach (tv[n]) begin
            for (int a = 1; a < 5; a++) wreg(a[3:0], tv[n][a - 1]);
            acc(1'b0, 1'b0, 4'h0, 32'h0);
            push(tv[n][4], tv[n][5]);
            drain();
            $display("test correction %0d done", n);
        end
        wreg(4'h0, 32'h8);
        wreg(4'h1, 32'h5A8);
        acc(1'b0, 1'b0, 4'h0, 32'h0);
        push(1000, -2000);
        drain();
        $display("test halved gain recovery done");
        end_sim();
    end
endmodule : test_coarse_mixer_iq_correction
